// ---- core/lprr_link.sv ----
// link-layer handling of hard reset, notify and abandon rejects
// assumes upstream decode of dwords into lprr_rx_t and an align slot request
`timescale 1ns/1ns
`default_nettype none
module lprr_link (
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire logic                 phy_reset_done,
    input  wire logic                 oob_active,
    input  wire logic                 ident_done,
    input  wire logic                 is_target,
    input  wire logic                 is_expander,
    input  wire logic                 peer_ssp_target,
    input  wire logic                 encl_ready,
    input  wire lprr_pkg::lprr_rx_t   rx,
    input  wire logic                 fwd_valid,
    input  wire lprr_pkg::lprr_prim_t fwd_prim,
    input  wire logic                 align_slot,
    input  wire logic                 align_subst_ok,
    input  wire logic                 start_req_any,
    input  wire logic                 spinup_other_port,
    input  wire logic                 open_pending,
    input  wire logic                 open_is_stp,
    input  wire lprr_pkg::lprr_open_t open_in,
    output logic                      hard_reset_ff,
    output logic                      spinup_pulse_ff,
    output logic                      spinup_start_ff,
    output logic                      req_abandon_ff,
    output lprr_pkg::lprr_rej_t       abandon_code_ff,
    output lprr_pkg::lprr_tx_t        tx_ff,
    output logic                      rej_valid_ff,
    output lprr_pkg::lprr_rej_t       rej_code_ff
);
    import lprr_pkg::*;

    typedef struct packed {
        lprr_phase_t phase;
        logic        hard_reset;
        logic        spinup_pulse;
        logic        spinup_start;
        logic        req_abandon;
        lprr_rej_t   abandon_code;
        lprr_tx_t    tx;
        logic        rej_valid;
        lprr_rej_t   rej_code;
        logic [1:0]  align_idx;
        logic        first_sent;
        logic        spin_due;
        logic [31:0] period_cnt;
    } lprr_st_t;

    lprr_st_t st_ff;
    lprr_st_t nxt_st;
    logic [3:0] ntfy_ready;
    logic       slot_sent;
    logic       ntfy_sent;

    assign slot_sent = st_ff.tx.valid
        && (st_ff.tx.prim == LPRR_PRIM_ALIGN || st_ff.tx.prim == LPRR_PRIM_NOTIFY);
    assign ntfy_sent = st_ff.tx.valid && st_ff.tx.prim == LPRR_PRIM_NOTIFY;

    lprr_spacer u_spacer (
        .clk       (clk),
        .reset_n   (reset_n),
        .slot_sent (slot_sent),
        .ntfy_sent (ntfy_sent),
        .ntfy_ver  (st_ff.tx.ntfy_ver),
        .ready_ff  (ntfy_ready)
    );

    always_comb begin
        logic may_ntfy;
        logic rx_rej;
        lprr_rej_t rc;
        may_ntfy = 1'b0;
        rx_rej   = 1'b0;
        rc       = LPRR_REJ_NONE;
        nxt_st   = st_ff;
        nxt_st.hard_reset   = 1'b0;
        nxt_st.spinup_pulse = 1'b0;
        nxt_st.spinup_start = 1'b0;
        nxt_st.req_abandon  = 1'b0;
        nxt_st.rej_valid    = 1'b0;
        nxt_st.tx.valid     = 1'b0;

        // link phase tracking
        case (st_ff.phase)
            LPRR_PH_RESET: if (oob_active) nxt_st.phase = LPRR_PH_OOB;
            LPRR_PH_OOB:   if (phy_reset_done) nxt_st.phase = LPRR_PH_READY;
            LPRR_PH_READY: if (ident_done) nxt_st.phase = LPRR_PH_IDENT;
                           else if (oob_active) nxt_st.phase = LPRR_PH_OOB;
            LPRR_PH_IDENT: if (oob_active) nxt_st.phase = LPRR_PH_OOB;
            default:       nxt_st.phase = LPRR_PH_RESET;
        endcase

        // receive side
        if (rx.valid) begin
            case (rx.prim)
                LPRR_PRIM_HRESET: begin
                    if (st_ff.phase == LPRR_PH_READY) begin
                        nxt_st.hard_reset = 1'b1;
                    end
                end
                LPRR_PRIM_NOTIFY: begin
                    // reserved versions fall through with no effect
                    if (is_target && rx.code[1:0] == NTFY_SPINUP) begin
                        nxt_st.spinup_pulse = 1'b1;
                    end
                end
                LPRR_PRIM_OREJ: rx_rej = 1'b1;
                default: ;
            endcase
        end

        // permission alone never starts media; a start request must be pending
        if (is_target && start_req_any
            && (nxt_st.spinup_pulse || spinup_other_port)) begin
            nxt_st.spinup_start = 1'b1;
        end

        // abandon-class rejects received by the originator
        if (rx_rej && open_pending) begin
            case (rx.code)
                4'(LPRR_REJ_BAD_DEST), 4'(LPRR_REJ_RATE), 4'(LPRR_REJ_PROTO),
                4'(LPRR_REJ_WRONG_DST): begin
                    nxt_st.req_abandon  = 1'b1;
                    nxt_st.abandon_code = lprr_rej_t'(rx.code);
                end
                4'(LPRR_REJ_RSVD_AB0), 4'(LPRR_REJ_RSVD_AB1),
                4'(LPRR_REJ_RSVD_AB2), 4'(LPRR_REJ_RSVD_AB3): begin
                    nxt_st.req_abandon  = 1'b1;
                    nxt_st.abandon_code = LPRR_REJ_WRONG_DST;
                end
                4'(LPRR_REJ_STP_BUSY): begin
                    nxt_st.req_abandon  = 1'b1;
                    nxt_st.abandon_code = open_is_stp ? LPRR_REJ_STP_BUSY
                                                      : LPRR_REJ_WRONG_DST;
                end
                default: ;
            endcase
        end

        // incoming open request evaluation, expander routing first
        if (open_in.valid) begin
            if (open_in.is_expander && open_in.route_back && open_in.bad_dest_pref) begin
                rc = LPRR_REJ_BAD_DEST;
            end else if (!open_in.rate_ok) begin
                rc = LPRR_REJ_RATE;
            end else if (!open_in.is_expander && !open_in.addr_match) begin
                rc = LPRR_REJ_WRONG_DST;
            end else if (!open_in.is_expander && !open_in.proto_ok) begin
                rc = LPRR_REJ_PROTO;
            end else if (!open_in.is_expander && open_in.is_stp && open_in.stp_busy) begin
                rc = LPRR_REJ_STP_BUSY;
            end
            nxt_st.rej_valid = (rc != LPRR_REJ_NONE);
            nxt_st.rej_code  = rc;
        end

        // spinup scheduling on initiator or expander ends
        if (!is_target && peer_ssp_target && encl_ready) begin
            if (!st_ff.first_sent) begin
                nxt_st.spin_due = 1'b1;
            end else if (st_ff.period_cnt >= SPINUP_PERIOD_CYC - 1) begin
                nxt_st.spin_due   = 1'b1;
                nxt_st.period_cnt = '0;
            end else begin
                nxt_st.period_cnt = st_ff.period_cnt + 32'h1;
            end
        end

        // transmit slot: align rotation with optional notify substitution
        may_ntfy = st_ff.spin_due && align_subst_ok && !oob_active
            && st_ff.phase != LPRR_PH_OOB && st_ff.phase != LPRR_PH_RESET
            && ntfy_ready[NTFY_SPINUP];
        if (align_slot) begin
            nxt_st.tx.valid     = 1'b1;
            nxt_st.tx.align_idx = st_ff.align_idx;
            nxt_st.tx.ntfy_ver  = NTFY_SPINUP;
            nxt_st.tx.code      = 4'h0;
            // notify consumes a rotation position to keep the cycle simple
            nxt_st.align_idx = (st_ff.align_idx == ALIGN_VARIANTS) ? 2'h0
                                                                 : st_ff.align_idx + 2'h1;
            if (may_ntfy) begin
                nxt_st.tx.prim   = LPRR_PRIM_NOTIFY;
                nxt_st.spin_due  = 1'b0;
                nxt_st.first_sent = 1'b1;
            end else begin
                nxt_st.tx.prim = LPRR_PRIM_ALIGN;
            end
        end else if (fwd_valid) begin
            nxt_st.tx.valid     = 1'b1;
            nxt_st.tx.align_idx = st_ff.align_idx;
            nxt_st.tx.ntfy_ver  = NTFY_SPINUP;
            nxt_st.tx.code      = 4'h0;
            // a forwarded notify would dodge the slot and spacing checks
            if (fwd_prim == LPRR_PRIM_NOTIFY) begin
                nxt_st.tx.prim = LPRR_PRIM_ALIGN;
            end else begin
                nxt_st.tx.prim = fwd_prim;
            end
            // forwarded aligns keep the rotation moving too
            if (nxt_st.tx.prim == LPRR_PRIM_ALIGN) begin
                nxt_st.align_idx = (st_ff.align_idx == ALIGN_VARIANTS) ? 2'h0
                                                                     : st_ff.align_idx + 2'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_ff <= '{phase: LPRR_PH_RESET, abandon_code: LPRR_REJ_NONE,
                       rej_code: LPRR_REJ_NONE, tx: '{valid: 1'b0, prim: LPRR_PRIM_OTHER,
                       align_idx: 2'h0, ntfy_ver: 2'h0, code: 4'h0}, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign hard_reset_ff   = st_ff.hard_reset;
    assign spinup_pulse_ff = st_ff.spinup_pulse;
    assign spinup_start_ff = st_ff.spinup_start;
    assign req_abandon_ff  = st_ff.req_abandon;
    assign abandon_code_ff = st_ff.abandon_code;
    assign tx_ff           = st_ff.tx;
    assign rej_valid_ff    = st_ff.rej_valid;
    assign rej_code_ff     = st_ff.rej_code;

    hard_reset_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        hard_reset_ff |-> $past(st_ff.phase) == LPRR_PH_READY)
        else $error("hard reset outside allowed window");
    hard_reset_take_a: assert property (@(posedge clk) disable iff (!reset_n)
        (rx.valid && rx.prim == LPRR_PRIM_HRESET && st_ff.phase == LPRR_PH_READY)
        |=> hard_reset_ff)
        else $error("hard reset not raised");
    spinup_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
        spinup_pulse_ff |-> $past(rx.valid && rx.prim == LPRR_PRIM_NOTIFY && is_target
                                  && rx.code[1:0] == NTFY_SPINUP))
        else $error("spinup pulse without spinup notify");
    rsvd_notify_a: assert property (@(posedge clk) disable iff (!reset_n)
        (rx.valid && rx.prim == LPRR_PRIM_NOTIFY && rx.code[1:0] != NTFY_SPINUP)
        |=> !spinup_pulse_ff)
        else $error("reserved notify acted on");
    no_fwd_notify_a: assert property (@(posedge clk) disable iff (!reset_n)
        (is_expander && !align_slot && fwd_valid && fwd_prim == LPRR_PRIM_NOTIFY)
        |=> tx_ff.prim == LPRR_PRIM_ALIGN)
        else $error("notify forwarded");
    oob_no_notify_a: assert property (@(posedge clk) disable iff (!reset_n)
        (align_slot && oob_active) |=> tx_ff.prim == LPRR_PRIM_ALIGN)
        else $error("notify during oob");
    notify_gap_a: assert property (@(posedge clk) disable iff (!reset_n)
        (tx_ff.valid && tx_ff.prim == LPRR_PRIM_NOTIFY)
        |=> !(tx_ff.valid && tx_ff.prim == LPRR_PRIM_NOTIFY) [*3])
        else $error("notify repeated too soon");
    rsvd_abandon_a: assert property (@(posedge clk) disable iff (!reset_n)
        (rx.valid && rx.prim == LPRR_PRIM_OREJ && open_pending
         && rx.code == 4'(LPRR_REJ_RSVD_AB2))
        |=> req_abandon_ff && abandon_code_ff == LPRR_REJ_WRONG_DST)
        else $error("reserved abandon mishandled");
    rate_reject_a: assert property (@(posedge clk) disable iff (!reset_n)
        (open_in.valid && !open_in.rate_ok && !open_in.route_back)
        |=> rej_valid_ff && rej_code_ff == LPRR_REJ_RATE)
        else $error("rate reject missing");
    bad_dest_reject_a: assert property (@(posedge clk) disable iff (!reset_n)
        (open_in.valid && open_in.is_expander && open_in.route_back && open_in.bad_dest_pref)
        |=> rej_valid_ff && rej_code_ff == LPRR_REJ_BAD_DEST)
        else $error("bad destination reject missing");
    wrong_dest_reject_a: assert property (@(posedge clk) disable iff (!reset_n)
        (open_in.valid && open_in.rate_ok && !open_in.is_expander && !open_in.addr_match)
        |=> rej_valid_ff && rej_code_ff == LPRR_REJ_WRONG_DST)
        else $error("wrong destination reject missing");
    proto_reject_a: assert property (@(posedge clk) disable iff (!reset_n)
        (open_in.valid && open_in.rate_ok && !open_in.is_expander && open_in.addr_match
         && !open_in.proto_ok)
        |=> rej_valid_ff && rej_code_ff == LPRR_REJ_PROTO)
        else $error("protocol reject missing");
    spinup_start_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        spinup_start_ff |-> $past(is_target && start_req_any))
        else $error("spinup started without start request");
endmodule // lprr_link
`default_nettype wire

// ---- core/lprr_pkg.sv ----
// package for the link primitive reset/notify/reject block
// assumes dword-level primitive decode happens upstream
package lprr_pkg;
    localparam int unsigned CLK_HZ          = 50000000;
    localparam int unsigned SPINUP_PERIOD_US = 1000;
    localparam int unsigned SPINUP_PERIOD_CYC = SPINUP_PERIOD_US * (CLK_HZ / 1000000);
    localparam int unsigned NTFY_GAP        = 3;
    localparam logic [1:0]  NTFY_GAP_W      = 2'h3;
    localparam logic [1:0]  ALIGN_VARIANTS  = 2'h3;

    // received/transmitted primitive class
    typedef enum logic [3:0] {
        LPRR_PRIM_OTHER  = 4'h0,
        LPRR_PRIM_ALIGN  = 4'h1,
        LPRR_PRIM_NOTIFY = 4'h2,
        LPRR_PRIM_HRESET = 4'h3,
        LPRR_PRIM_OREJ   = 4'h4
    } lprr_prim_t;

    // notify versions
    localparam logic [1:0] NTFY_SPINUP = 2'h0;
    localparam logic [1:0] NTFY_RSVD0  = 2'h1;
    localparam logic [1:0] NTFY_RSVD1  = 2'h2;
    localparam logic [1:0] NTFY_RSVD2  = 2'h3;

    // abandon-class reject versions
    typedef enum logic [3:0] {
        LPRR_REJ_BAD_DEST  = 4'h0,
        LPRR_REJ_RATE      = 4'h1,
        LPRR_REJ_PROTO     = 4'h2,
        LPRR_REJ_RSVD_AB0  = 4'h3,
        LPRR_REJ_RSVD_AB1  = 4'h4,
        LPRR_REJ_RSVD_AB2  = 4'h5,
        LPRR_REJ_RSVD_AB3  = 4'h6,
        LPRR_REJ_STP_BUSY  = 4'h7,
        LPRR_REJ_WRONG_DST = 4'h8,
        LPRR_REJ_NONE      = 4'hf
    } lprr_rej_t;

    typedef struct packed {
        logic       valid;
        lprr_prim_t prim;
        logic [3:0] code;
    } lprr_rx_t;

    typedef struct packed {
        logic       valid;
        logic       is_stp;
        logic       rate_ok;
        logic       proto_ok;
        logic       addr_match;
        logic       route_back;
        logic       stp_busy;
        logic       is_expander;
        logic       bad_dest_pref;
    } lprr_open_t;

    typedef struct packed {
        logic       valid;
        lprr_prim_t prim;
        logic [1:0] align_idx;
        logic [1:0] ntfy_ver;
        logic [3:0] code;
    } lprr_tx_t;

    typedef enum logic [3:0] {
        LPRR_PH_RESET = 4'b0001,
        LPRR_PH_OOB   = 4'b0010,
        LPRR_PH_READY = 4'b0100,
        LPRR_PH_IDENT = 4'b1000
    } lprr_phase_t;
endpackage

// ---- core/lprr_spacer.sv ----
// per-version notify spacing counters
// assumes one tx slot per clock with slot_sent marking a sent align or notify
`timescale 1ns/1ns
`default_nettype none
module lprr_spacer (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       slot_sent,
    input  wire logic       ntfy_sent,
    input  wire logic [1:0] ntfy_ver,
    output logic      [3:0] ready_ff
);
    import lprr_pkg::*;
    typedef struct packed {
        logic [3:0][1:0] gap;
    } lprr_sp_t;
    lprr_sp_t st_ff;
    lprr_sp_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        for (int i = 0; i < 4; i++) begin
            if (ntfy_sent && ntfy_ver == 2'(i)) begin
                nxt_st.gap[i] = 2'h0;
            end else if (slot_sent && st_ff.gap[i] != NTFY_GAP_W) begin
                nxt_st.gap[i] = st_ff.gap[i] + 2'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_ff    <= '{gap: {4{NTFY_GAP_W}}};
            ready_ff <= 4'hf;
        end else begin
            st_ff <= nxt_st;
            for (int i = 0; i < 4; i++) begin
                ready_ff[i] <= (nxt_st.gap[i] == NTFY_GAP_W);
            end
        end
    end
endmodule // lprr_spacer
`default_nettype wire

// ---- testbench/lprr_peer.sv ----
// peer phy model: sends primitives on rx and watches the sent stream
// assumes one tx slot per clock; slot_ok marks an align slot open to notify
`timescale 1ns/1ns
`default_nettype none
module lprr_peer (
    input  wire logic               clk,
    input  wire logic               reset_n,
    input  wire lprr_pkg::lprr_tx_t tx,
    input  wire logic               slot_ok,
    input  wire logic               rot_on,
    output lprr_pkg::lprr_rx_t      rx,
    output logic [7:0]              viol,
    output logic [15:0]             ntfy_cnt
);
    import lprr_pkg::*;
    logic       ok_q;
    logic       rot_v;
    logic [1:0] rot;
    logic [1:0] gap [4];
    logic [7:0] v_n;
    logic       slot;

    initial begin
        rx = '0;
        viol = '0;
        ntfy_cnt = '0;
    end

    // released lines show the inverse so stale data never looks valid
    task automatic send(input lprr_prim_t p, input logic [3:0] c);
        rx <= '{valid: 1'b1, prim: p, code: c};
        @(posedge clk);
        #1;
        rx <= '{valid: 1'b0, prim: lprr_prim_t'(~p), code: ~c};
    endtask

    always @(posedge clk) begin
        slot = tx.valid && (tx.prim == LPRR_PRIM_ALIGN || tx.prim == LPRR_PRIM_NOTIFY);
        v_n = viol;
        ok_q <= slot_ok;
        if (tx.valid && tx.prim == LPRR_PRIM_NOTIFY && !ok_q)
            v_n = v_n + 8'h1;
        if (!reset_n || !rot_on)
            rot_v <= 1'b0;
        else if (slot) begin
            // notify takes a position, so the next align skips one index
            if (rot_v && tx.prim == LPRR_PRIM_ALIGN && tx.align_idx != rot)
                v_n = v_n + 8'h1;
            rot_v <= rot_v | (tx.prim == LPRR_PRIM_ALIGN);
            rot <= (tx.prim == LPRR_PRIM_ALIGN ? tx.align_idx : rot) + 2'h1;
        end
        for (int i = 0; i < 4; i++) begin
            if (!reset_n)
                gap[i] <= NTFY_GAP_W;
            else if (slot && tx.prim == LPRR_PRIM_NOTIFY && tx.ntfy_ver == 2'(i)) begin
                if (gap[i] != NTFY_GAP_W)
                    v_n = v_n + 8'h1;
                gap[i] <= 2'h0;
            end else if (slot && gap[i] != NTFY_GAP_W)
                gap[i] <= gap[i] + 2'h1;
        end
        if (reset_n && slot && tx.prim == LPRR_PRIM_NOTIFY && tx.ntfy_ver == NTFY_SPINUP)
            ntfy_cnt <= ntfy_cnt + 16'h1;
        viol <= v_n;
    end
endmodule // lprr_peer
`default_nettype wire

// ---- testbench/tb_link_primitive_reset_notify_reject.sv ----
// self-checking bench for the link primitive block
// assumes lprr_peer drives rx and watches tx; events noted in expq
`timescale 1ns/1ns
`default_nettype none
module tb_link_primitive_reset_notify_reject;
    import lprr_pkg::*;
    logic clk, reset_n, phy_reset_done, oob_active, ident_done, is_target;
    logic is_expander, peer_ssp_target, encl_ready, fwd_valid, align_slot;
    logic align_subst_ok, start_req_any, spinup_other_port, open_pending;
    logic open_is_stp, hard_reset_ff, spinup_pulse_ff, spinup_start_ff;
    logic req_abandon_ff, rej_valid_ff;
    lprr_prim_t fwd_prim;
    lprr_open_t open_in;
    lprr_rx_t   rx;
    lprr_tx_t   tx_ff;
    lprr_rej_t  abandon_code_ff, rej_code_ff;
    logic [7:0]  viol;
    logic [15:0] ntfy_cnt;
    logic [7:0]  expq [$];
    int fails;
    int checks;
    int seed;

    lprr_link u_dut (.clk(clk), .reset_n(reset_n), .phy_reset_done(phy_reset_done),
        .oob_active(oob_active), .ident_done(ident_done), .is_target(is_target),
        .is_expander(is_expander), .peer_ssp_target(peer_ssp_target),
        .encl_ready(encl_ready), .rx(rx), .fwd_valid(fwd_valid), .fwd_prim(fwd_prim),
        .align_slot(align_slot), .align_subst_ok(align_subst_ok),
        .start_req_any(start_req_any), .spinup_other_port(spinup_other_port),
        .open_pending(open_pending), .open_is_stp(open_is_stp), .open_in(open_in),
        .hard_reset_ff(hard_reset_ff), .spinup_pulse_ff(spinup_pulse_ff),
        .spinup_start_ff(spinup_start_ff), .req_abandon_ff(req_abandon_ff),
        .abandon_code_ff(abandon_code_ff), .tx_ff(tx_ff), .rej_valid_ff(rej_valid_ff),
        .rej_code_ff(rej_code_ff));

    lprr_peer u_peer (.clk(clk), .reset_n(reset_n), .tx(tx_ff),
        .slot_ok(align_slot & align_subst_ok & ~oob_active),
        .rot_on(phy_reset_done & ~oob_active), .rx(rx), .viol(viol), .ntfy_cnt(ntfy_cnt));

    always #10 clk = ~clk;

    task automatic give_verdict();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // an event with nothing noted meets ff and fails
    task automatic pop(input logic [7:0] got);
        logic [7:0] e;
        e = 8'hff;
        if (expq.size() > 0)
            e = expq.pop_front();
        cmp8(got, e);
    endtask

    always @(negedge clk) begin
        if (reset_n === 1'b1) begin
            if (hard_reset_ff === 1'b1) pop(8'h10);
            if (spinup_pulse_ff === 1'b1) pop(8'h20);
            if (spinup_start_ff === 1'b1) pop(8'h30);
            if (req_abandon_ff === 1'b1) pop({4'h4, abandon_code_ff});
            if (rej_valid_ff === 1'b1) pop({4'h5, rej_code_ff});
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic rxp(input lprr_prim_t p, input logic [3:0] c);
        u_peer.send(p, c);
        tick(2);
    endtask

    // leftover notes mean an expected event never came
    task automatic done(input string s);
        tick(3);
        cmp8(8'(expq.size()), 8'h00);
        expq.delete();
        $display("test %s done", s);
    endtask

    task automatic run(input int n, input bit oob);
        logic [31:0] r;
        for (int i = 0; i < n; i++) begin
            r = $random(seed);
            align_slot = r[0] | r[1];
            align_subst_ok = r[2] | r[3];
            fwd_valid = ~align_slot & r[4];
            fwd_prim = r[5] ? LPRR_PRIM_NOTIFY : LPRR_PRIM_ALIGN;
            oob_active = oob && (i % 4000 < 40);
            // non-target end: start and reject inputs toggle at random and must have no effect
            start_req_any = r[6];
            spinup_other_port = r[7];
            open_pending = r[8];
            open_is_stp = r[9];
            tick(1);
        end
        align_slot = 1'b0;
        fwd_valid = 1'b0;
        oob_active = 1'b0;
        {start_req_any, spinup_other_port, open_pending, open_is_stp} = '0;
    endtask

    initial begin
        #(20 * 60000);
        fails++;
        give_verdict();
    end

    initial begin
        logic [3:0]  e;
        logic [16:0] oc [7];
        seed = 3366;
        {clk, reset_n, phy_reset_done, oob_active, ident_done, is_target} = '0;
        {is_expander, peer_ssp_target, encl_ready, fwd_valid, align_slot} = '0;
        {align_subst_ok, start_req_any, spinup_other_port, open_pending, open_is_stp} = '0;
        fwd_prim = LPRR_PRIM_OTHER;
        open_in = '0;
        tick(5);
        cmp8({hard_reset_ff, spinup_pulse_ff, spinup_start_ff, req_abandon_ff,
              rej_valid_ff, tx_ff.valid, 2'h0}, 8'h00);
        cmp8({abandon_code_ff, rej_code_ff}, 8'hff);
        reset_n = 1'b1;
        tick(1);
        rxp(LPRR_PRIM_HRESET, 4'h0);
        oob_active = 1'b1;
        rxp(LPRR_PRIM_HRESET, 4'h0);
        oob_active = 1'b0;
        phy_reset_done = 1'b1;
        tick(1);
        expq.push_back(8'h10);
        rxp(LPRR_PRIM_HRESET, 4'h0);
        expq.push_back(8'h10);
        rxp(LPRR_PRIM_HRESET, 4'h0);
        ident_done = 1'b1;
        tick(1);
        rxp(LPRR_PRIM_HRESET, 4'h0);
        done("hard reset");
        is_target = 1'b1;
        // hard resets above, no start request: permission alone never starts
        for (int v = 0; v < 4; v++) begin
            if (v == 0) expq.push_back(8'h20);
            rxp(LPRR_PRIM_NOTIFY, 4'(v));
        end
        start_req_any = 1'b1;
        expq.push_back(8'h20);
        expq.push_back(8'h30);
        rxp(LPRR_PRIM_NOTIFY, {2'h0, NTFY_SPINUP});
        expq.push_back(8'h30);
        spinup_other_port = 1'b1;
        tick(1);
        spinup_other_port = 1'b0;
        tick(2);
        start_req_any = 1'b0;
        done("notify rx");
        rxp(LPRR_PRIM_OREJ, 4'h0);
        open_pending = 1'b1;
        for (int c = 0; c < 9; c++) begin
            e = (c >= 3 && c <= 7) ? 4'h8 : 4'(c);
            expq.push_back({4'h4, e});
            rxp(LPRR_PRIM_OREJ, 4'(c));
        end
        open_is_stp = 1'b1;
        expq.push_back(8'h47);
        rxp(LPRR_PRIM_OREJ, 4'h7);
        open_pending = 1'b0;
        open_is_stp = 1'b0;
        done("reject rx");
        is_target = 1'b0;
        is_expander = 1'b1;
        oc[0] = {9'h170, 8'h00};
        oc[1] = {9'h17b, 8'h50};
        oc[2] = {9'h130, 8'h51};
        oc[3] = {9'h160, 8'h58};
        oc[4] = {9'h150, 8'h52};
        oc[5] = {9'h1f4, 8'h57};
        oc[6] = {9'h120, 8'h51};
        for (int i = 0; i < 7; i++) begin
            if (oc[i][7:0] != 8'h00) expq.push_back(oc[i][7:0]);
            open_in = oc[i][16:8];
            tick(1);
            open_in = {1'b0, ~oc[i][15:8]};
            tick(2);
        end
        done("open reject");
        peer_ssp_target = 1'b1;
        run(200, 1'b0);
        cmp8(ntfy_cnt[7:0], 8'h00);
        encl_ready = 1'b1;
        run(1000, 1'b0);
        cmp8(ntfy_cnt[7:0], 8'h01);
        // period is a package constant, so the full interval is run
        run(50500, 1'b1);
        cmp8({7'h0, ntfy_cnt > 16'h1}, 8'h01);
        cmp8(viol, 8'h00);
        done("notify tx");
        // mid-run reset drops back to the reset phase
        reset_n = 1'b0;
        tick(2);
        reset_n = 1'b1;
        cmp8({abandon_code_ff, rej_code_ff}, 8'hff);
        rxp(LPRR_PRIM_HRESET, 4'h0);
        done("mid reset");
        give_verdict();
    end
endmodule // tb_link_primitive_reset_notify_reject
`default_nettype wire
